// ==== rtl/fsac_pkg.sv ====
// Shared constants and types of the flash sector access controller
package fsac_pkg;

    // ****************************************
    // Sector layout
    // ****************************************
    localparam logic [15:0] SECT0_BASE     = 16'hF000;
    localparam logic [15:0] SECT1_BASE     = 16'hE000;
    localparam int unsigned SECTOR_KB      = 4;
    localparam int unsigned ONE_SECT_KB    = 4;
    localparam int unsigned TWO_SECT_KB    = 8;
    localparam int unsigned FLASH_KB_DFLT  = 60;

    // ****************************************
    // Option byte and reset values
    // ****************************************
    localparam int unsigned OPT_PROT_BIT   = 0;
    localparam logic        PROT_RESET     = 1'b1;

    // ****************************************
    // Serial link frame
    // ****************************************
    localparam int unsigned FRAME_BITS     = 32;
    localparam int unsigned READ_BITS      = 8;
    localparam int unsigned FR_OP_LSB      = 24;
    localparam int unsigned FR_ADDR_LSB    = 8;
    localparam int unsigned FR_DATA_LSB    = 0;

    // ****************************************
    // Pin synchroniser slots
    // ****************************************
    localparam int unsigned PIN_CLK        = 0;
    localparam int unsigned PIN_DATA       = 1;
    localparam int unsigned PIN_VSEL       = 2;
    localparam int unsigned PIN_TOOL       = 3;
    localparam int unsigned PIN_COUNT      = 4;

    typedef enum logic [2:0] {
        OP_PROG       = 3'h0,
        OP_SECT_ERASE = 3'h1,
        OP_MASS_ERASE = 3'h2,
        OP_OPTION_WR  = 3'h3,
        OP_READ       = 3'h4
    } fsac_op_e;

    typedef struct packed {
        fsac_op_e    op;
        logic [15:0] addr;
        logic [7:0]  data;
    } fsac_req_s;

endpackage

// ==== rtl/fsac_ctrl.sv ====
// Flash sector access controller: mode, lock, protection and serial link
`timescale 1ns/1ps
module fsac_ctrl #(
    parameter int unsigned FLASH_KB  = fsac_pkg::FLASH_KB_DFLT,
    parameter bit          MASK_PART = 1'b0,
    parameter bit          MASK_PROT = 1'b0
) (
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    input  wire logic                core_req_valid,
    input  wire fsac_pkg::fsac_req_s core_req,
    output logic                     core_done,
    output logic                     core_err,
    output logic                     flash_cmd_valid,
    output fsac_pkg::fsac_req_s      flash_cmd,
    input  wire logic                flash_done,
    input  wire logic [7:0]          flash_rdata,
    input  wire logic [7:0]          option_byte,
    input  wire logic                incircuit_serial_clock,
    input  wire logic                incircuit_serial_data_in,
    output logic                     incircuit_serial_data_out,
    output logic                     incircuit_serial_data_oe,
    input  wire logic                programming_voltage_select,
    input  wire logic                tool_attached,
    input  wire logic                app_data_out,
    input  wire logic                app_data_oe,
    output logic                     app_serial_clock,
    output logic                     app_serial_data,
    output logic                     incircuit_comm_mode,
    output logic                     readout_protect_option_bit,
    output logic                     low_voltage_detector_en
);

    // ****************************************
    // Sector decode
    // ****************************************
    localparam int unsigned NSECT = (FLASH_KB <= fsac_pkg::ONE_SECT_KB) ? 1 :
                                    (FLASH_KB <= fsac_pkg::TWO_SECT_KB) ? 2 : 3;
    localparam logic [16:0] LOW_ADDR = 17'(32'h10000 - FLASH_KB * 1024);

    function automatic logic [1:0] sector_of(input logic [15:0] a);
        if (a >= fsac_pkg::SECT0_BASE)
            return 2'h0;
        else if (a >= fsac_pkg::SECT1_BASE)
            return 2'h1;
        return 2'h2;
    endfunction

    function automatic logic present(input logic [15:0] a);
        return ({1'b0, a} >= LOW_ADDR) && (32'(sector_of(a)) < NSECT);
    endfunction

    function automatic logic allowed(input fsac_pkg::fsac_req_s r, input logic priv,
                                     input logic prot);
        unique case (r.op)
            fsac_pkg::OP_PROG, fsac_pkg::OP_SECT_ERASE:
                return present(r.addr) && !prot
                       && (priv || sector_of(r.addr) != 2'h0);
            fsac_pkg::OP_MASS_ERASE: return priv && !prot;
            fsac_pkg::OP_OPTION_WR:  return priv && !MASK_PART;
            fsac_pkg::OP_READ:       return 1'b1;
            default:                 return 1'b0;
        endcase
    endfunction

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } fsac_state_e;

    // ****************************************
    // State
    // ****************************************
    logic [fsac_pkg::PIN_COUNT-1:0]  meta_reg, sync_reg, meta_next, sync_next;
    logic                            clk_prev_reg, clk_prev_next;
    logic [fsac_pkg::FRAME_BITS-1:0] rx_reg, rx_next;
    logic [5:0]                      rx_cnt_reg, rx_cnt_next;
    logic                            pend_reg, pend_next;
    logic [7:0]                      tx_reg, tx_next;
    logic [3:0]                      tx_cnt_reg, tx_cnt_next;
    logic                            link_out_reg, link_out_next;
    logic                            pin_out_reg, pin_out_next, pin_oe_reg, pin_oe_next;
    fsac_state_e                     state_reg, state_next;
    fsac_pkg::fsac_req_s             cur_reg, cur_next, cmd_reg, cmd_next;
    logic                            src_link_reg, src_link_next;
    logic                            purge_reg, purge_next;
    logic                            cmd_v_reg, cmd_v_next;
    logic                            done_reg, done_next, err_reg, err_next;
    logic                            prot_reg, prot_next, loaded_reg, loaded_next;
    logic                            mode_reg, mode_next, lvd_reg, lvd_next;
    logic                            aclk_reg, aclk_next, adat_reg, adat_next;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        fsac_pkg::fsac_req_s   fr;
        fsac_pkg::fsac_req_s   pick;
        logic                  rise;
        logic                  fall;
        logic                  frame_done;
        logic                  take;
        // Request sits in the low bits of the frame; the top bits are padding
        fr            = fsac_pkg::fsac_req_s'(
                            rx_reg[fsac_pkg::FR_DATA_LSB +: $bits(fsac_pkg::fsac_req_s)]);
        pick          = fr;
        meta_next     = {tool_attached, programming_voltage_select,
                         incircuit_serial_data_in, incircuit_serial_clock};
        sync_next     = meta_reg;
        clk_prev_next = sync_reg[fsac_pkg::PIN_CLK];
        rise          = sync_reg[fsac_pkg::PIN_CLK] && !clk_prev_reg;
        fall          = !sync_reg[fsac_pkg::PIN_CLK] && clk_prev_reg;
        rx_next       = rx_reg;
        rx_cnt_next   = rx_cnt_reg;
        tx_next       = tx_reg;
        tx_cnt_next   = tx_cnt_reg;
        link_out_next = link_out_reg;
        frame_done    = 1'b0;
        take          = 1'b0;
        state_next    = state_reg;
        cur_next      = cur_reg;
        cmd_next      = cmd_reg;
        src_link_next = src_link_reg;
        purge_next    = purge_reg;
        cmd_v_next    = 1'b0;
        done_next     = 1'b0;
        err_next      = 1'b0;
        prot_next     = prot_reg;
        loaded_next   = 1'b1;
        // Mode only while the tool holds voltage select and is plugged in
        mode_next     = sync_reg[fsac_pkg::PIN_VSEL] && sync_reg[fsac_pkg::PIN_TOOL];
        lvd_next      = !prot_reg;

        // Option byte read once after reset; a mask part keeps its build value
        if (!loaded_reg)
            prot_next = MASK_PART ? MASK_PROT : option_byte[fsac_pkg::OPT_PROT_BIT];

        // Receive frames MSB first on link clock rises, outside a read reply
        if (!mode_reg) begin
            rx_cnt_next = '0;
        end else if (rise && tx_cnt_reg == '0) begin
            rx_next = {rx_reg[fsac_pkg::FRAME_BITS-2:0], sync_reg[fsac_pkg::PIN_DATA]};
            if (rx_cnt_reg == 6'(fsac_pkg::FRAME_BITS - 1)) begin
                rx_cnt_next = '0;
                frame_done  = 1'b1;
            end else begin
                rx_cnt_next = rx_cnt_reg + 6'h1;
            end
        end
        // Reply bits change on falling edges; the tool reads each one well after the fall
        if (fall && tx_cnt_reg != '0) begin
            link_out_next = tx_reg[6];
            tx_next       = {tx_reg[6:0], 1'b0};
            tx_cnt_next   = tx_cnt_reg - 4'h1;
        end

        unique case (state_reg)
            ST_IDLE: begin
                if (pend_reg && mode_reg) begin
                    take          = 1'b1;
                    src_link_next = 1'b1;
                end else if (core_req_valid && loaded_reg) begin
                    pick          = core_req;
                    src_link_next = 1'b0;
                end
                if ((pend_reg && mode_reg) || (core_req_valid && loaded_reg)) begin
                    cur_next = pick;
                    if (!allowed(pick, mode_reg, prot_reg)) begin
                        done_next = !(pend_reg && mode_reg);
                        err_next  = !(pend_reg && mode_reg);
                    end else begin
                        state_next = ST_WAIT;
                        cmd_v_next = 1'b1;
                        cmd_next   = pick;
                        // Clearing protection wipes the whole array first
                        if (pick.op == fsac_pkg::OP_OPTION_WR && prot_reg
                            && !pick.data[fsac_pkg::OPT_PROT_BIT]) begin
                            purge_next   = 1'b1;
                            cmd_next.op  = fsac_pkg::OP_MASS_ERASE;
                        end
                    end
                end
            end
            ST_WAIT: begin
                if (flash_done) begin
                    if (purge_reg) begin
                        purge_next = 1'b0;
                        cmd_v_next = 1'b1;
                        cmd_next   = cur_reg;
                    end else begin
                        state_next = ST_IDLE;
                        done_next  = !src_link_reg;
                        if (cur_reg.op == fsac_pkg::OP_OPTION_WR)
                            prot_next = cur_reg.data[fsac_pkg::OPT_PROT_BIT];
                        if (cur_reg.op == fsac_pkg::OP_READ && src_link_reg) begin
                            tx_next       = prot_reg ? 8'h00 : flash_rdata;
                            tx_cnt_next   = 4'(fsac_pkg::READ_BITS);
                            link_out_next = prot_reg ? 1'b0 : flash_rdata[7];
                        end
                    end
                end
            end
            default: state_next = ST_IDLE;
        endcase

        // Frame arrival wins over a take in the same cycle
        pend_next = frame_done || (pend_reg && !take);
        // Attached tool owns both link pins, busy or not
        aclk_next    = sync_reg[fsac_pkg::PIN_TOOL] ? 1'b0 : sync_reg[fsac_pkg::PIN_CLK];
        adat_next    = sync_reg[fsac_pkg::PIN_TOOL] ? 1'b0 : sync_reg[fsac_pkg::PIN_DATA];
        pin_oe_next  = sync_reg[fsac_pkg::PIN_TOOL] ? (tx_cnt_next != '0) : app_data_oe;
        pin_out_next = sync_reg[fsac_pkg::PIN_TOOL] ? link_out_next : app_data_out;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg     <= '0;
            sync_reg     <= '0;
            clk_prev_reg <= 1'b0;
            rx_reg       <= '0;
            rx_cnt_reg   <= '0;
            pend_reg     <= 1'b0;
            tx_reg       <= '0;
            tx_cnt_reg   <= '0;
            link_out_reg <= 1'b0;
            pin_out_reg  <= 1'b0;
            pin_oe_reg   <= 1'b0;
            state_reg    <= ST_IDLE;
            cur_reg      <= '0;
            cmd_reg      <= '0;
            src_link_reg <= 1'b0;
            purge_reg    <= 1'b0;
            cmd_v_reg    <= 1'b0;
            done_reg     <= 1'b0;
            err_reg      <= 1'b0;
            prot_reg     <= fsac_pkg::PROT_RESET;
            loaded_reg   <= 1'b0;
            mode_reg     <= 1'b0;
            lvd_reg      <= 1'b0;
            aclk_reg     <= 1'b0;
            adat_reg     <= 1'b0;
        end else begin
            meta_reg     <= meta_next;
            sync_reg     <= sync_next;
            clk_prev_reg <= clk_prev_next;
            rx_reg       <= rx_next;
            rx_cnt_reg   <= rx_cnt_next;
            pend_reg     <= pend_next;
            tx_reg       <= tx_next;
            tx_cnt_reg   <= tx_cnt_next;
            link_out_reg <= link_out_next;
            pin_out_reg  <= pin_out_next;
            pin_oe_reg   <= pin_oe_next;
            state_reg    <= state_next;
            cur_reg      <= cur_next;
            cmd_reg      <= cmd_next;
            src_link_reg <= src_link_next;
            purge_reg    <= purge_next;
            cmd_v_reg    <= cmd_v_next;
            done_reg     <= done_next;
            err_reg      <= err_next;
            prot_reg     <= prot_next;
            loaded_reg   <= loaded_next;
            mode_reg     <= mode_next;
            lvd_reg      <= lvd_next;
            aclk_reg     <= aclk_next;
            adat_reg     <= adat_next;
        end
    end

    assign core_done                  = done_reg;
    assign core_err                   = err_reg;
    assign flash_cmd_valid            = cmd_v_reg;
    assign flash_cmd                  = cmd_reg;
    assign incircuit_serial_data_out  = pin_out_reg;
    assign incircuit_serial_data_oe   = pin_oe_reg;
    assign app_serial_clock           = aclk_reg;
    assign app_serial_data            = adat_reg;
    assign incircuit_comm_mode        = mode_reg;
    assign readout_protect_option_bit = prot_reg;
    assign low_voltage_detector_en    = lvd_reg;

    // ****************************************
    // Checks
    // ****************************************
    logic wr_cmd;
    assign wr_cmd = cmd_v_reg && (cmd_reg.op == fsac_pkg::OP_PROG
                                  || cmd_reg.op == fsac_pkg::OP_SECT_ERASE);

    a_sector0_app_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_cmd && sector_of(cmd_reg.addr) == 2'h0 |-> $past(mode_reg))
        else $error("sector 0 changed outside in-circuit mode");
    a_protect_no_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_cmd |-> !prot_reg)
        else $error("write issued while protected");
    a_absent_sector: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_cmd |-> present(cmd_reg.addr))
        else $error("write to an absent sector");
    a_purge_before_opt: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cmd_v_reg && cmd_reg.op == fsac_pkg::OP_OPTION_WR && prot_reg
        && !cmd_reg.data[fsac_pkg::OPT_PROT_BIT] |-> $past(purge_reg))
        else $error("protection cleared without full erase");
    a_mass_erase_priv: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cmd_v_reg && cmd_reg.op == fsac_pkg::OP_MASS_ERASE |-> $past(mode_reg))
        else $error("mass erase from the application");
    a_lvd_protect: assert property (@(posedge sys_clk) disable iff (!rst_n)
        prot_reg ##1 prot_reg |-> !low_voltage_detector_en)
        else $error("detector enabled while protected");
    a_tool_hides_pins: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(sync_reg[fsac_pkg::PIN_TOOL]) |-> !app_serial_clock && !app_serial_data)
        else $error("link pins seen by the application");
    a_refuse_no_cmd: assert property (@(posedge sys_clk) disable iff (!rst_n)
        core_err |-> core_done && !cmd_v_reg && $past(state_reg) == ST_IDLE)
        else $error("refused request reached the array");

endmodule // fsac_ctrl

// ==== tb/fsac_tool_model.sv ====
// Programming tool model that drives the in-circuit serial link
`timescale 1ns/1ps
module fsac_tool_model (
    output logic      clk_pin,
    output logic      data_bit,
    output logic      data_en,
    input  wire logic data_line,
    input  wire logic line_driven
);
    initial begin
        clk_pin  = 1'b0;
        data_bit = 1'b0;
        data_en  = 1'b0;
    end

    // Clock idles low between frames; 48 ns period keeps each phase over 3 core cycles
    task automatic send_frame(input logic [31:0] frame);
        for (int i = 31; i >= 0; i--) begin
            data_bit = frame[i];
            data_en  = 1'b1;
            #12;
            clk_pin = 1'b1;
            #24;
            clk_pin = 1'b0;
            #12;
        end
        data_en = 1'b0;
    endtask

    // Reply bits are read well after each fall so the device's pin sync has settled
    task automatic read_reply(output logic [7:0] b, output logic ok);
        fork
            wait (line_driven === 1'b1);
            #2000;
        join_any
        disable fork;
        #1;
        ok   = line_driven;
        b[7] = data_line;
        for (int i = 6; i >= -1; i--) begin
            clk_pin = 1'b1;
            #25;
            clk_pin = 1'b0;
            #40;
            if (i >= 0) begin
                b[i] = data_line;
            end
        end
    endtask
endmodule // fsac_tool_model

// ==== tb/tb_flash_sector_access_control.sv ====
// Self-checking testbench of the flash sector access controller
`timescale 1ns/1ps
module tb_flash_sector_access_control;
    logic                sys_clk, rst_n, core_req_valid, flash_done, tool_attached, vsel;
    logic                core_done, core_err, flash_cmd_valid, dout, doe, app_clk, app_dat;
    logic                mode, prot, low_voltage_detector, tclk, tbit, ten, din, e, ok, app_oe;
    logic [7:0]          option_byte, b;
    fsac_pkg::fsac_req_s core_req, flash_cmd;
    fsac_pkg::fsac_op_e  ops[$];
    int                  fails, cmp_count, cycles, pend;

    // Data line is pulled up when nobody drives it
    assign din = doe ? dout : (ten ? tbit : 1'b1);

    fsac_ctrl DUT (.sys_clk(sys_clk), .rst_n(rst_n), .core_req_valid(core_req_valid),
        .core_req(core_req), .core_done(core_done), .core_err(core_err),
        .flash_cmd_valid(flash_cmd_valid), .flash_cmd(flash_cmd), .flash_done(flash_done),
        .flash_rdata(8'hA5), .option_byte(option_byte), .incircuit_serial_clock(tclk),
        .incircuit_serial_data_in(din), .incircuit_serial_data_out(dout),
        .incircuit_serial_data_oe(doe), .programming_voltage_select(vsel),
        .tool_attached(tool_attached), .app_data_out(1'b0), .app_data_oe(app_oe),
        .app_serial_clock(app_clk), .app_serial_data(app_dat), .incircuit_comm_mode(mode),
        .readout_protect_option_bit(prot), .low_voltage_detector_en(low_voltage_detector));
    fsac_tool_model tool (.clk_pin(tclk), .data_bit(tbit), .data_en(ten), .data_line(din),
        .line_driven(doe));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Array stand-in: logs each command and ends it two cycles later
    initial begin
        flash_done = 1'b0;
        pend       = 0;
        forever begin
            @(posedge sys_clk);
            #1;
            flash_done = 1'b0;
            if (flash_cmd_valid === 1'b1) begin
                ops.push_back(flash_cmd.op);
                pend = 2;
            end else if (pend > 0) begin
                pend--;
                flash_done = (pend == 0);
            end
        end
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_sim();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic do_reset(input logic [7:0] opt);
        rst_n         = 1'b0;
        option_byte   = opt;
        tool_attached = 1'b0;
        vsel          = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(prot, 1'b1, "protect in reset");
        rst_n = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic set_tool(input logic on);
        int n;
        n             = 0;
        tool_attached = on;
        vsel          = on;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (mode !== on && n < 20);
        chk(mode, on, "mode");
    endtask

    task automatic core_op(input fsac_pkg::fsac_op_e op, input logic [15:0] a, output logic err);
        int n;
        n = 0;
        ops.delete();
        core_req       = '{op: op, addr: a, data: 8'h5A};
        core_req_valid = 1'b1;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (core_done !== 1'b1 && n < 50);
        err            = (core_done === 1'b1) ? core_err : 1'bx;
        core_req_valid = 1'b0;
    endtask

    task automatic link_read(input logic [15:0] a);
        fork
            tool.send_frame({5'h00, fsac_pkg::OP_READ, a, 8'h00});
            begin
                @(posedge tclk);
                repeat (4) @(posedge sys_clk);
                #1;
                chk(app_clk, 1'b0, "clock hidden");
            end
        join
        tool.read_reply(b, ok);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_app();
        chk(prot, 1'b0, "protect off");
        chk(low_voltage_detector, 1'b1, "detector on");
        chk(app_dat, 1'b1, "pin visible");
        app_oe = 1'b1;
        @(posedge sys_clk);
        #1;
        chk({doe, dout}, 2'b10, "app drives pin");
        repeat (3) @(posedge sys_clk);
        #1;
        chk(app_dat, 1'b0, "app sees pin");
        app_oe = 1'b0;
        core_op(fsac_pkg::OP_PROG, 16'h0800, e);
        chk(e, 1'b1, "absent sector");
        core_op(fsac_pkg::OP_READ, 16'hF000, e);
        chk({e, ops[0]}, {1'b0, fsac_pkg::OP_READ}, "core read");
        core_op(fsac_pkg::OP_PROG, 16'hF010, e);
        chk(e, 1'b1, "sector 0 locked");
        chk(ops.size(), 0, "no command");
        core_op(fsac_pkg::OP_PROG, 16'hE010, e);
        chk(e, 1'b0, "sector 1 open");
        chk({5'h00, flash_cmd}, {5'h00, fsac_pkg::OP_PROG, 16'hE010, 8'h5A}, "byte cmd");
        core_op(fsac_pkg::OP_SECT_ERASE, 16'hD000, e);
        chk({e, ops[0]}, {1'b0, fsac_pkg::OP_SECT_ERASE}, "sector 2 erase");
        core_op(fsac_pkg::OP_MASS_ERASE, 16'h0000, e);
        chk(e, 1'b1, "mass erase refused");
        core_op(fsac_pkg::OP_OPTION_WR, 16'h0000, e);
        chk(e, 1'b1, "option write refused");
    endtask

    task automatic t_tool();
        set_tool(1'b1);
        chk(app_dat, 1'b0, "pin hidden");
        app_oe = 1'b1;
        @(posedge sys_clk);
        #1;
        chk(doe, 1'b0, "app drive blocked");
        app_oe = 1'b0;
        core_op(fsac_pkg::OP_PROG, 16'hF010, e);
        chk(e, 1'b0, "sector 0 in mode");
        core_op(fsac_pkg::OP_MASS_ERASE, 16'h0000, e);
        chk({e, ops[0]}, {1'b0, fsac_pkg::OP_MASS_ERASE}, "mass erase");
        link_read(16'hF123);
        chk({ok, b}, {1'b1, 8'hA5}, "link read");
        set_tool(1'b0);
    endtask

    task automatic t_prot();
        do_reset(8'h01);
        chk({prot, low_voltage_detector}, 2'b10, "protected");
        set_tool(1'b1);
        core_op(fsac_pkg::OP_PROG, 16'hE010, e);
        chk(e, 1'b1, "write refused");
        link_read(16'hF123);
        chk({ok, b}, {1'b1, 8'h00}, "read blanked");
        core_op(fsac_pkg::OP_OPTION_WR, 16'h0000, e);
        chk({e, 8'(ops.size())}, {1'b0, 8'd2}, "purge then option");
        chk({ops[0], ops[1]}, {fsac_pkg::OP_MASS_ERASE, fsac_pkg::OP_OPTION_WR}, "order");
        @(posedge sys_clk);
        #1;
        chk({prot, low_voltage_detector}, 2'b01, "unprotected");
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        fails          = 0;
        cmp_count      = 0;
        cycles         = 0;
        core_req_valid = 1'b0;
        app_oe         = 1'b0;
        core_req       = '{op: fsac_pkg::OP_READ, addr: 16'h0000, data: 8'h00};
        do_reset(8'h00);
        t_app();
        t_tool();
        t_prot();
        end_sim();
    end
endmodule // tb_flash_sector_access_control
